// file: hw/pwr_params.svh
`ifndef PWR_PARAMS_SVH
`define PWR_PARAMS_SVH

// Register indices; the AHB byte address is four times the index.
`define IDX_PORT1_CTRL 8'h1d
`define IDX_PORT2_CTRL 8'h2d
`define IDX_GLOBAL_MODE 8'hc3
`define IDX_GO_SLEEP 8'hc4

// Field positions.
`define MODE_MSB 1
`define MODE_LSB 0
`define PLL_OFF_BIT 2
`define PORT_PD_BIT 3

// Reset values.
`define RST_PORT_CTRL 8'h00
`define RST_GLOBAL_MODE 3'h0
`define RST_GO_SLEEP 8'h00

// AHB-Lite encodings.
`define HRESP_OKAY 1'h0

// Timing at the 20 MHz reference clock.
`define CLK_PERIOD_NS 50
`define LINK_PULSE_NS 120
`define LINK_PULSE_CYC ((`LINK_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define LINK_PERIOD_S 1
`define LINK_PERIOD_CYC ((`LINK_PERIOD_S * 1000000000) / `CLK_PERIOD_NS)
`define SLEEP_TICK_US 1000
`define SLEEP_TICK_CYC ((`SLEEP_TICK_US * 1000) / `CLK_PERIOD_NS)

`endif

// file: hw/pwr_pkg.sv
package pwr_pkg;

    typedef enum logic [1:0] {
        MODE_NORMAL = 2'h0,
        MODE_ENERGY = 2'h1,
        MODE_SOFT_PD = 2'h2,
        MODE_SAVE = 2'h3
    } mode_t;

    typedef enum logic [2:0] {
        ST_NORMAL,
        ST_ED_AWAKE,
        ST_ED_SLEEP,
        ST_SOFT_PD,
        ST_PS_WATCH,
        ST_PS_RXOFF
    } state_t;

endpackage

// file: hw/pwr_reg_if.sv
interface pwr_reg_if;
    logic wr_stb;
    logic [7:0] wr_idx;
    logic [7:0] wr_data;
    logic [7:0] rd_idx;
    logic [7:0] rd_data;

    modport bus (output wr_stb, output wr_idx, output wr_data, output rd_idx, input rd_data);
    modport regs (input wr_stb, input wr_idx, input wr_data, input rd_idx, output rd_data);
endinterface

// file: hw/ahb_reg_slave.sv
`include "pwr_params.svh"

module ahb_reg_slave (
    // Clock and reset
    input logic ref_clk_i,
    input logic rst_i,
    // AHB-Lite slave
    input logic hsel_i,
    input logic [31:0] haddr_i,
    input logic [1:0] htrans_i,
    input logic hwrite_i,
    input logic hready_i,
    input logic [31:0] hwdata_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    // Register side
    pwr_reg_if.bus rif
);
    logic wr_pend;
    logic rd_pend;
    logic [7:0] pend_idx;
    logic pend_ok;

    wire take = hsel_i && hready_i && htrans_i[1];
    wire in_range = (haddr_i[31:10] == 22'h000000);

    // Reads take one wait state so that a write just ahead is always visible.
    assign rif.wr_stb = wr_pend && pend_ok;
    assign rif.wr_idx = pend_idx;
    assign rif.wr_data = hwdata_i[7:0];
    assign rif.rd_idx = pend_idx;

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            wr_pend <= 1'b0;
            rd_pend <= 1'b0;
            pend_idx <= 8'h00;
            pend_ok <= 1'b0;
            hrdata_o <= 32'h00000000;
            hreadyout_o <= 1'b1;
            hresp_o <= `HRESP_OKAY;
        end else begin
            wr_pend <= take && hwrite_i;
            rd_pend <= take && !hwrite_i;
            hreadyout_o <= !(take && !hwrite_i);
            hresp_o <= `HRESP_OKAY;
            if (take) begin
                pend_idx <= haddr_i[9:2];
                pend_ok <= in_range;
            end
            if (rd_pend) begin
                hrdata_o <= pend_ok ? {24'h000000, rif.rd_data} : 32'h00000000;
            end
        end
    end
endmodule // ahb_reg_slave

// file: hw/sleep_timer.sv
`include "pwr_params.svh"

module sleep_timer #(
    parameter int TICK_CYC = `SLEEP_TICK_CYC,
    parameter int PERIOD_CYC = `LINK_PERIOD_CYC
) (
    // Clock and reset
    input logic ref_clk_i,
    input logic rst_i,
    // Idle timing
    input logic run_i,
    input logic energy_i,
    input logic [7:0] go_sleep_i,
    output logic expired_o,
    // Link pulses
    input logic pulse_en_i,
    output logic pulse_o
);
    localparam logic [24:0] TICK_LAST = 25'(TICK_CYC - 1);
    localparam logic [24:0] PERIOD_LAST = 25'(PERIOD_CYC - 1);
    localparam logic [24:0] PULSE_CYC = 25'(`LINK_PULSE_CYC);

    logic [24:0] tick_cnt;
    logic [8:0] idle_cnt;
    logic [24:0] per_cnt;

    wire restart = !run_i || energy_i;
    wire tick = (tick_cnt == TICK_LAST);
    wire [8:0] next_idle = (tick && idle_cnt != 9'h1ff) ? idle_cnt + 9'h001 : idle_cnt;

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            tick_cnt <= 25'h0000000;
            idle_cnt <= 9'h000;
            expired_o <= 1'b0;
        end else if (restart) begin
            tick_cnt <= 25'h0000000;
            idle_cnt <= 9'h000;
            expired_o <= 1'b0;
        end else begin
            tick_cnt <= tick ? 25'h0000000 : tick_cnt + 25'h0000001;
            idle_cnt <= next_idle;
            expired_o <= (idle_cnt > {1'b0, go_sleep_i});
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            per_cnt <= 25'h0000000;
            pulse_o <= 1'b0;
        end else if (!pulse_en_i) begin
            per_cnt <= 25'h0000000;
            pulse_o <= 1'b0;
        end else begin
            per_cnt <= (per_cnt == PERIOD_LAST) ? 25'h0000000 : per_cnt + 25'h0000001;
            pulse_o <= (per_cnt < PULSE_CYC);
        end
    end
endmodule // sleep_timer

// file: hw/switch_power_mode_control.sv
// The AHB-Lite slave port is this design's own decision.
`include "pwr_params.svh"

module switch_power_mode_control #(
    parameter int SLEEP_TICK_CYC = `SLEEP_TICK_CYC,
    parameter int LINK_PERIOD_CYC = `LINK_PERIOD_CYC
) (
    // Clock and reset
    input logic ref_clk_i,
    input logic rst_i,
    // AHB-Lite register bus
    input logic hsel_i,
    input logic [31:0] haddr_i,
    input logic [1:0] htrans_i,
    input logic hwrite_i,
    input logic [2:0] hsize_i,
    input logic hready_i,
    input logic [31:0] hwdata_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    // Line status pins: energy_i has one bit per copper port, an_enable_i one bit for both
    input logic [1:0] energy_i,
    input logic an_enable_i,
    // Power controls
    output logic pll_clk_en_o,
    output logic pll_pd_o,
    output logic [1:0] phy_tx_en_o,
    output logic [1:0] phy_rx_en_o,
    output logic mac_en_o,
    output logic host_if_en_o,
    output logic link_pulse_o,
    output logic low_power_o
);
    pwr_reg_if rif ();

    logic [7:0] port_ctrl [2];
    logic [2:0] global_mode;
    logic [7:0] go_sleep;
    pwr_pkg::state_t state;
    pwr_pkg::state_t next_state;
    logic [1:0] energy_meta;
    logic [1:0] energy_sync;
    logic an_meta;
    logic an_sync;
    logic sleep_expired;

    function automatic logic idx_is(input logic [7:0] idx, input logic [7:0] reg_idx);
        return idx == reg_idx;
    endfunction

    // Only the width of the transfer matters to the master; the register is the low byte.
    wire unused_size = |hsize_i;

    ahb_reg_slave u_bus (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .hsel_i(hsel_i),
        .haddr_i(haddr_i),
        .htrans_i(htrans_i),
        .hwrite_i(hwrite_i),
        .hready_i(hready_i),
        .hwdata_i(hwdata_i),
        .hrdata_o(hrdata_o),
        .hreadyout_o(hreadyout_o),
        .hresp_o(hresp_o),
        .rif(rif.bus)
    );

    // Register decode.
    // Soft power down freezes every register but the global mode register, whose mode field must stay
    // writable so that the host can bring the device back.
    wire regs_open = (state != pwr_pkg::ST_SOFT_PD);
    wire wr_port1 = rif.wr_stb && regs_open && idx_is(rif.wr_idx, `IDX_PORT1_CTRL);
    wire wr_port2 = rif.wr_stb && regs_open && idx_is(rif.wr_idx, `IDX_PORT2_CTRL);
    wire wr_mode = rif.wr_stb && idx_is(rif.wr_idx, `IDX_GLOBAL_MODE);
    wire wr_sleep = rif.wr_stb && regs_open && idx_is(rif.wr_idx, `IDX_GO_SLEEP);

    assign rif.rd_data = idx_is(rif.rd_idx, `IDX_PORT1_CTRL) ? port_ctrl[0] :
                         idx_is(rif.rd_idx, `IDX_PORT2_CTRL) ? port_ctrl[1] :
                         idx_is(rif.rd_idx, `IDX_GLOBAL_MODE) ? {5'h00, global_mode} :
                         idx_is(rif.rd_idx, `IDX_GO_SLEEP) ? go_sleep : 8'h00;

    // The bus stays alive in every mode, otherwise soft power down could never be left.
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            port_ctrl[0] <= `RST_PORT_CTRL;
            port_ctrl[1] <= `RST_PORT_CTRL;
            global_mode <= `RST_GLOBAL_MODE;
            go_sleep <= `RST_GO_SLEEP;
        end else begin
            if (wr_port1) port_ctrl[0] <= rif.wr_data;
            if (wr_port2) port_ctrl[1] <= rif.wr_data;
            if (wr_mode) global_mode <= rif.wr_data[`PLL_OFF_BIT:`MODE_LSB];
            if (wr_sleep) go_sleep <= rif.wr_data;
        end
    end

    // Line status comes from the analog front end and is synchronised first.
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            energy_meta <= 2'h0;
            energy_sync <= 2'h0;
            an_meta <= 1'b0;
            an_sync <= 1'b0;
        end else begin
            energy_meta <= energy_i;
            energy_sync <= energy_meta;
            an_meta <= an_enable_i;
            an_sync <= an_meta;
        end
    end

    wire [1:0] mode_f = global_mode[`MODE_MSB:`MODE_LSB];
    wire pll_off = global_mode[`PLL_OFF_BIT];
    wire energy_any = |energy_sync;
    wire [1:0] port_pd = {port_ctrl[1][`PORT_PD_BIT], port_ctrl[0][`PORT_PD_BIT]};

    sleep_timer #(
        .TICK_CYC(SLEEP_TICK_CYC),
        .PERIOD_CYC(LINK_PERIOD_CYC)
    ) u_timer (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .run_i(state == pwr_pkg::ST_ED_AWAKE),
        .energy_i(energy_any),
        .go_sleep_i(go_sleep),
        .expired_o(sleep_expired),
        .pulse_en_i(state == pwr_pkg::ST_ED_SLEEP),
        .pulse_o(link_pulse_o)
    );

    // The mode field alone picks the family of states; line status moves inside a family.
    always_comb begin
        next_state = state;
        case (mode_f)
            pwr_pkg::MODE_NORMAL: begin
                next_state = pwr_pkg::ST_NORMAL;
            end
            pwr_pkg::MODE_ENERGY: begin
                if (state == pwr_pkg::ST_ED_SLEEP) begin
                    next_state = energy_any ? pwr_pkg::ST_ED_AWAKE : pwr_pkg::ST_ED_SLEEP;
                end else if (state == pwr_pkg::ST_ED_AWAKE) begin
                    next_state = sleep_expired ? pwr_pkg::ST_ED_SLEEP : pwr_pkg::ST_ED_AWAKE;
                end else begin
                    next_state = pwr_pkg::ST_ED_AWAKE;
                end
            end
            pwr_pkg::MODE_SOFT_PD: begin
                next_state = pwr_pkg::ST_SOFT_PD;
            end
            pwr_pkg::MODE_SAVE: begin
                if (an_sync && !energy_any) begin
                    next_state = pwr_pkg::ST_PS_RXOFF;
                end else begin
                    next_state = pwr_pkg::ST_PS_WATCH;
                end
            end
            default: begin
                next_state = pwr_pkg::ST_NORMAL;
            end
        endcase
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state <= pwr_pkg::ST_NORMAL;
        end else begin
            state <= next_state;
        end
    end

    // Block enables per state.
    wire st_sleep = (state == pwr_pkg::ST_ED_SLEEP);
    wire st_soft = (state == pwr_pkg::ST_SOFT_PD);
    wire st_rxoff = (state == pwr_pkg::ST_PS_RXOFF);
    wire core_on = !st_sleep && !st_soft;
    wire next_rx_on = core_on && !st_rxoff;
    wire [1:0] next_tx = {2{core_on}} & ~port_pd;
    wire [1:0] next_rx = {2{next_rx_on}} & ~port_pd;

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            pll_clk_en_o <= 1'b1;
            pll_pd_o <= 1'b0;
            phy_tx_en_o <= 2'h3;
            phy_rx_en_o <= 2'h3;
            mac_en_o <= 1'b1;
            host_if_en_o <= 1'b1;
            low_power_o <= 1'b0;
        end else begin
            pll_clk_en_o <= core_on;
            pll_pd_o <= st_sleep && pll_off;
            phy_tx_en_o <= next_tx;
            phy_rx_en_o <= next_rx;
            mac_en_o <= core_on;
            host_if_en_o <= core_on;
            low_power_o <= st_sleep;
        end
    end

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);

    mode_decode_a: assert property (
        (mode_f == 2'h2) |=> (state == pwr_pkg::ST_SOFT_PD))
        else $error("mode code 10 did not select soft power down");

    reset_normal_a: assert property (
        $past(rst_i) |-> (mode_f == 2'h0) && (state == pwr_pkg::ST_NORMAL))
        else $error("mode field not normal after reset");

    normal_power_a: assert property (
        (state == pwr_pkg::ST_NORMAL) && (port_pd == 2'h0) |=>
            pll_clk_en_o && mac_en_o && host_if_en_o && (phy_tx_en_o == 2'h3)
            && (phy_rx_en_o == 2'h3))
        else $error("normal mode left a block unpowered");

    mode_write_a: assert property (
        (state == pwr_pkg::ST_NORMAL) && wr_mode && (rif.wr_data[1:0] == 2'h1)
            |=> ##1 (state == pwr_pkg::ST_ED_AWAKE))
        else $error("write of energy code did not leave normal mode");

    go_sleep_a: assert property (
        (state == pwr_pkg::ST_ED_AWAKE) && (mode_f == 2'h1) && sleep_expired
            |=> (state == pwr_pkg::ST_ED_SLEEP))
        else $error("idle time expired but device stayed awake");

    early_sleep_a: assert property (
        (state == pwr_pkg::ST_ED_AWAKE) && energy_any |=> !sleep_expired)
        else $error("idle timer expired while energy present");

    wake_up_a: assert property (
        (state == pwr_pkg::ST_ED_SLEEP) && (mode_f == 2'h1) && energy_any
            |=> (state == pwr_pkg::ST_ED_AWAKE) ##1 mac_en_o)
        else $error("energy did not wake the device");

    sleep_off_a: assert property (
        st_sleep |=> !pll_clk_en_o && !mac_en_o && !host_if_en_o && low_power_o
            && (phy_tx_en_o == 2'h0))
        else $error("low power state left circuitry on");

    pulse_width_a: assert property (
        link_pulse_o [*3] |=> !link_pulse_o)
        else $error("link pulse wider than three cycles");

    pulse_place_a: assert property (
        $rose(link_pulse_o) |-> $past(st_sleep))
        else $error("link pulse outside low power state");

    pll_pd_a: assert property (
        st_sleep && pll_off |=> pll_pd_o)
        else $error("pll not powered down with bit two set");

    soft_pd_a: assert property (
        st_soft |=> !pll_clk_en_o && !mac_en_o && (phy_rx_en_o == 2'h0)
            && $stable(go_sleep))
        else $error("soft power down left a block running");

    soft_exit_a: assert property (
        st_soft && wr_mode && (rif.wr_data[1:0] == 2'h0)
            |=> ##1 (state == pwr_pkg::ST_NORMAL))
        else $error("soft power down not left on normal code");

    save_engage_a: assert property (
        st_rxoff |-> $past(mode_f == 2'h3) && $past(an_sync) && !$past(energy_any))
        else $error("receiver switched off without its conditions");

    save_keep_a: assert property (
        st_rxoff && (port_pd == 2'h0) |=> pll_clk_en_o && mac_en_o && host_if_en_o
            && (phy_tx_en_o == 2'h3) && (phy_rx_en_o == 2'h0))
        else $error("power saving state gated the wrong blocks");

    save_restore_a: assert property (
        st_rxoff && (mode_f == 2'h3) && energy_any |=> ##1 (phy_rx_en_o == ~port_pd))
        else $error("line activity did not restore the receiver");

    save_leave_a: assert property (
        st_rxoff && wr_mode && (rif.wr_data[1:0] == 2'h2) |=> ##1 st_soft)
        else $error("write did not leave power saving mode");

    port_pd_a: assert property (
        port_pd[0] && !port_pd[1] && (state == pwr_pkg::ST_NORMAL)
            |=> !phy_tx_en_o[0] && phy_tx_en_o[1])
        else $error("port power down not independent");

    port_off_a: assert property (
        ((phy_tx_en_o | phy_rx_en_o) & $past(port_pd)) == 2'h0)
        else $error("powered down port still enabled");

    regs_frozen_a: assert property (
        st_soft |=> $stable(port_ctrl[0]) && $stable(port_ctrl[1]))
        else $error("port control changed during soft power down");

    awake_traffic_a: assert property (
        (state == pwr_pkg::ST_ED_AWAKE) && (port_pd == 2'h0) |=> pll_clk_en_o && mac_en_o
            && host_if_en_o && (phy_tx_en_o == 2'h3) && (phy_rx_en_o == 2'h3))
        else $error("awake energy state did not pass traffic");

    normal_family_a: assert property (
        (mode_f == 2'h0) |=> (state == pwr_pkg::ST_NORMAL))
        else $error("normal code did not select normal state");

    energy_family_a: assert property (
        (mode_f == 2'h1) |=> (state == pwr_pkg::ST_ED_AWAKE) || st_sleep)
        else $error("energy code selected a foreign state");

    save_family_a: assert property (
        (mode_f == 2'h3) |=> (state == pwr_pkg::ST_PS_WATCH) || st_rxoff)
        else $error("saving code selected a foreign state");

    pll_pd_sleep_a: assert property (
        pll_pd_o |-> low_power_o)
        else $error("pll powered down outside low power state");

    // Pulses must die within one cycle of the low power state; a pulse can run one cycle on into the awake state.
    pulse_quiet_a: assert property (
        !$past(st_sleep) |-> !link_pulse_o)
        else $error("link pulse while not in low power state");

    tx_kept_a: assert property (
        st_rxoff |=> (phy_tx_en_o == ~$past(port_pd)))
        else $error("power saving state stopped the transmitter");

    ed_cycle_c: cover property (
        st_sleep ##1 (state == pwr_pkg::ST_ED_AWAKE));
    soft_round_c: cover property (
        st_soft ##[1:50] (state == pwr_pkg::ST_NORMAL));
    save_round_c: cover property (
        st_rxoff ##[1:50] (state == pwr_pkg::ST_PS_WATCH));
    pulse_seen_c: cover property ($rose(link_pulse_o));
endmodule // switch_power_mode_control

// file: testbench/cable_partner.sv
module cable_partner (
    // Clock
    input wire logic ref_clk_i,
    // Scenario control
    input wire logic plug_i,
    input wire logic [3:0] lat_i,
    // Line energy seen by the device
    output logic [1:0] energy_o
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [3:0] cnt = 4'h0;
    logic held = 1'b0;

    // A slow partner takes lat_i + 1 cycles to show or drop energy after a plug change.
    always @(posedge ref_clk_i) begin
        if (plug_i == held) begin
            cnt <= 4'h0;
        end else if (cnt >= lat_i) begin
            held <= plug_i;
            cnt <= 4'h0;
        end else begin
            cnt <= cnt + 4'h1;
        end
    end

    assign energy_o = {held, held};
endmodule // cable_partner

// file: testbench/switch_power_mode_control_tb.sv
`include "pwr_params.svh"

module switch_power_mode_control_tb;
    timeunit 1ns;
    timeprecision 1ns;

    localparam int PER = 20;
    localparam logic [31:0] A_P1 = {22'h0, `IDX_PORT1_CTRL, 2'h0};
    localparam logic [31:0] A_P2 = {22'h0, `IDX_PORT2_CTRL, 2'h0};
    localparam logic [31:0] A_MODE = {22'h0, `IDX_GLOBAL_MODE, 2'h0};
    localparam logic [31:0] A_SLP = {22'h0, `IDX_GO_SLEEP, 2'h0};
    // Output vector: pll_en, pll_pd, tx[1:0], rx[1:0], mac, host, low_power.
    localparam logic [8:0] ALL = 9'h1ff;
    localparam logic [8:0] NORM = 9'h17e;
    localparam logic [8:0] PS_OFF = 9'h166;
    localparam logic [8:0] P1_PD = 9'h156;

    logic ref_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic hsel_i = 1'b0;
    logic hwrite_i = 1'b0;
    logic [1:0] htrans_i = 2'h0;
    logic [2:0] hsize_i = 3'h2;
    logic [31:0] haddr_i = 32'h0;
    logic [31:0] hwdata_i = 32'h0;
    logic an_en = 1'b0;
    logic plug = 1'b0;
    logic [3:0] lat = 4'h1;
    wire [31:0] hrdata_o;
    wire hreadyout_o, hresp_o;
    wire pll_clk_en_o, pll_pd_o, mac_en_o, host_if_en_o, link_pulse_o, low_power_o;
    wire [1:0] energy, phy_tx_en_o, phy_rx_en_o;
    wire [8:0] outs = {pll_clk_en_o, pll_pd_o, phy_tx_en_o, phy_rx_en_o, mac_en_o,
                       host_if_en_o, low_power_o};
    int fail_count = 0;
    int check_count = 0;
    int cycles = 0;
    int seed = 32'hea9b84f6;
    int n;
    int w;
    logic [31:0] exp_q[$];
    logic [31:0] v;
    logic rd_ph = 1'b0;
    logic r;

    cable_partner pm_u (.ref_clk_i(ref_clk_i), .plug_i(plug), .lat_i(lat), .energy_o(energy));

    switch_power_mode_control #(.SLEEP_TICK_CYC(4), .LINK_PERIOD_CYC(PER)) dut_u (
        .ref_clk_i(ref_clk_i), .rst_i(rst_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
        .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hready_i(hreadyout_o),
        .hwdata_i(hwdata_i), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
        .energy_i(energy), .an_enable_i(an_en), .pll_clk_en_o(pll_clk_en_o),
        .pll_pd_o(pll_pd_o), .phy_tx_en_o(phy_tx_en_o), .phy_rx_en_o(phy_rx_en_o),
        .mac_en_o(mac_en_o), .host_if_en_o(host_if_en_o), .link_pulse_o(link_pulse_o),
        .low_power_o(low_power_o));

    always #25 ref_clk_i = ~ref_clk_i;

    task check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task report_and_stop;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Ready is taken from the settled value before the edge that samples it.
    task wait_rdy;
        r = 1'b0;
        while (!r) begin
            @(negedge ref_clk_i) r = (hreadyout_o === 1'b1);
            @(posedge ref_clk_i);
        end
    endtask

    task bus(input logic wr, input logic [31:0] a, input logic [31:0] d, input logic [31:0] e);
        @(posedge ref_clk_i);
        hsel_i <= 1'b1;
        htrans_i <= 2'h2;
        haddr_i <= a;
        hwrite_i <= wr;
        wait_rdy;
        hsel_i <= 1'b0;
        htrans_i <= 2'h0;
        hwdata_i <= d;
        if (!wr) exp_q.push_back(e);
        wait_rdy;
    endtask

    task wait_out(input logic [8:0] m, input logic [8:0] e, input int lim);
        @(negedge ref_clk_i);
        for (n = 0; n < lim && (outs & m) !== e; n++) @(negedge ref_clk_i);
        check({23'h0, outs & m}, {23'h0, e});
    endtask

    // Read data is compared against the oldest note when the data phase completes.
    always @(negedge ref_clk_i) begin
        if (rd_ph && hreadyout_o === 1'b1) begin
            rd_ph = 1'b0;
            check(hrdata_o, exp_q.size() > 0 ? exp_q.pop_front() : 32'hdead0000);
            check({31'h0, hresp_o}, {31'h0, `HRESP_OKAY});
        end
        if (hsel_i && htrans_i[1] && !hwrite_i && hreadyout_o === 1'b1) rd_ph = 1'b1;
    end

    always @(posedge ref_clk_i) begin
        cycles++;
        if (cycles == 6000) begin
            fail_count++;
            report_and_stop;
        end
    end

    initial begin
        repeat (8) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        wait_out(ALL, NORM, 1);
        bus(0, A_P1, 0, 0);
        bus(0, A_P2, 0, 0);
        bus(0, A_MODE, 0, 0);
        bus(0, A_SLP, 0, 0);
        v = $random(seed);
        bus(1, 32'h400, v, 0);
        bus(0, 32'h400, 0, 0);
        bus(1, A_SLP, v, 0);
        // Soft power down must keep register contents intact.
        bus(1, A_MODE, 2, 0);
        wait_out(ALL, 9'h000, 8);
        bus(1, A_SLP, ~v, 0);
        bus(0, A_SLP, 0, {24'h0, v[7:0]});
        bus(0, A_MODE, 0, 2);
        bus(1, A_MODE, 0, 0);
        wait_out(ALL, NORM, 8);
        bus(1, A_SLP, 2, 0);
        bus(1, A_MODE, 5, 0);
        repeat (6) @(negedge ref_clk_i);
        check({31'h0, low_power_o}, 0);
        wait_out(9'h187, 9'h081, 40);
        for (n = 0; n < 40 && link_pulse_o !== 1'b1; n++) @(negedge ref_clk_i);
        for (w = 0; w < 10 && link_pulse_o === 1'b1; w++) @(negedge ref_clk_i);
        check(w, `LINK_PULSE_CYC);
        for (n = w; n < 40 && link_pulse_o !== 1'b1; n++) @(negedge ref_clk_i);
        check(n, PER);
        @(posedge ref_clk_i) plug <= 1'b1;
        wait_out(ALL, NORM, 20);
        repeat (30) @(negedge ref_clk_i);
        check({23'h0, outs}, {23'h0, NORM});
        @(posedge ref_clk_i) plug <= 1'b0;
        an_en <= 1'b1;
        bus(1, A_MODE, 3, 0);
        wait_out(ALL, PS_OFF, 30);
        @(posedge ref_clk_i) lat <= 4'h9;
        plug <= 1'b1;
        wait_out(ALL, NORM, 30);
        @(posedge ref_clk_i) an_en <= 1'b0;
        plug <= 1'b0;
        repeat (25) @(negedge ref_clk_i);
        check({23'h0, outs}, {23'h0, NORM});
        @(posedge ref_clk_i) an_en <= 1'b1;
        wait_out(ALL, PS_OFF, 30);
        bus(1, A_MODE, 2, 0);
        wait_out(ALL, 9'h000, 8);
        bus(1, A_MODE, 0, 0);
        bus(1, A_P1, 8, 0);
        wait_out(ALL, P1_PD, 8);
        bus(0, A_P1, 0, 8);
        bus(1, A_P1, 0, 0);
        wait_out(ALL, NORM, 8);
        report_and_stop;
    end
endmodule // switch_power_mode_control_tb
